//--- bench/msab_bank_monitor.sv
/* port assertions for the status and alarm bank.
   assumes one clock, core_clk, and asynchronous active-low resetn. */
`timescale 1ns/1ps
`include "msab_regs.vh"
module msab_bank_monitor (
    // clock, reset and register access
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_rdata,
    // pins, strobes and measurements
    input wire logic        tx_disable_pin,
    input wire logic        rate_select_input,
    input wire logic        power_on_analog_trip,
    input wire logic [5:0]  conv_done,
    input wire logic [15:0] temp_result, temp_thr_hi, temp_thr_lo,
    input wire logic [15:0] vcc_result, vcc_thr_hi, vcc_thr_lo,
    input wire logic [15:0] mona_result, mona_thr_hi, mona_thr_lo,
    input wire logic [15:0] monb_result, monb_thr_hi, monb_thr_lo,
    // observed controls
    input wire logic        tx_disabled,
    input wire logic        rate_select_output,
    input wire logic [7:0]  measurement_alarm_flags_a
);
    // one domain, so one clock and one disable for all
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    chk_txd_pin_or: assert property (tx_disable_pin |=> tx_disabled)
        else $error("transmit disable did not follow the pin");
    chk_rate_pin_or: assert property (rate_select_input |=> rate_select_output)
        else $error("rate select output did not follow the pin");
    chk_temperature_high_alarm_cmp: assert property (conv_done[5] |=> measurement_alarm_flags_a[7] ==
        ($signed($past(temp_result)) > $signed($past(temp_thr_hi))))
        else $error("temperature high alarm wrong");
    chk_temperature_low_alarm_cmp: assert property (conv_done[5] |=> measurement_alarm_flags_a[6] ==
        ($signed($past(temp_result)) < $signed($past(temp_thr_lo))))
        else $error("temperature low alarm wrong");
    chk_supply_high_alarm_cmp: assert property (conv_done[4] |=> measurement_alarm_flags_a[5] ==
        ($past(vcc_result) > $past(vcc_thr_hi))) else $error("supply high alarm wrong");
    chk_supply_low_alarm_cmp: assert property (conv_done[4] && !power_on_analog_trip |=>
        measurement_alarm_flags_a[4] == ($past(vcc_result) < $past(vcc_thr_lo)))
        else $error("supply low alarm wrong");
    chk_trip_sets_low: assert property (power_on_analog_trip |=> measurement_alarm_flags_a[4])
        else $error("supply low alarm not forced below trip");
    chk_mona_alarms: assert property (conv_done[3] |=> measurement_alarm_flags_a[3:2] ==
        {$past(mona_result) > $past(mona_thr_hi), $past(mona_result) < $past(mona_thr_lo)})
        else $error("monitor a alarms wrong");
    chk_monb_alarms: assert property (conv_done[2] |=> measurement_alarm_flags_a[1:0] ==
        {$past(monb_result) > $past(monb_thr_hi), $past(monb_result) < $past(monb_thr_lo)})
        else $error("monitor b alarms wrong");
    chk_alarm_hold: assert property (conv_done[5:2] == 4'h0 && !power_on_analog_trip
        |=> $stable(measurement_alarm_flags_a)) else $error("alarm moved without a result");
    chk_alarm_read: assert property (reg_rd && reg_addr == `MSAB_OFS_ALARM_A
        |=> reg_rdata == $past(measurement_alarm_flags_a)) else $error("alarm read mismatch");
endmodule // msab_bank_monitor

bind msab_bank msab_bank_monitor u_mon (.core_clk(core_clk), .resetn(resetn),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
    .tx_disable_pin(tx_disable_pin), .rate_select_input(rate_select_input),
    .power_on_analog_trip(power_on_analog_trip), .conv_done(conv_done),
    .temp_result(temp_result), .temp_thr_hi(temp_thr_hi), .temp_thr_lo(temp_thr_lo),
    .vcc_result(vcc_result), .vcc_thr_hi(vcc_thr_hi), .vcc_thr_lo(vcc_thr_lo),
    .mona_result(mona_result), .mona_thr_hi(mona_thr_hi), .mona_thr_lo(mona_thr_lo),
    .monb_result(monb_result), .monb_thr_hi(monb_thr_hi), .monb_thr_lo(monb_thr_lo),
    .tx_disabled(tx_disabled), .rate_select_output(rate_select_output),
    .measurement_alarm_flags_a(measurement_alarm_flags_a));

//--- bench/tb_top.sv
/* self-checking bench for the status and alarm bank.
   assumes reads answer one cycle after the strobe and inputs move on the falling edge. */
`timescale 1ns/1ps
module tb_top;
    // stimulus; pins packs txd, in1, rate, fault, los, trip from bit 5 down
    reg         core_clk = 1'b0;
    reg         resetn = 1'b0;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg  [7:0]  reg_addr = 8'h00;
    reg  [7:0]  reg_wdata = 8'h00;
    reg  [5:0]  pins = 6'h01;
    reg  [5:0]  conv_done = 6'h00;
    reg         coarse = 1'b0;
    reg  [15:0] m [0:11];
    wire [7:0]  reg_rdata;
    wire [7:0]  alarms;
    wire        tx_disabled;
    wire        rate_out;
    integer     n_errors = 0;
    integer     checks = 0;
    integer     i;
    // result, high and low for temp, supply, monitor a, monitor b; temp -2 catches unsigned use
    localparam [191:0] TV = {16'hFFFE, 16'h0001, 16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000,
                             16'h0005, 16'h0005, 16'h0006, 16'hFFFF, 16'h8000, 16'h0000};
    // 25 MHz clock
    always #20 core_clk = ~core_clk;
    msab_bank DUT (.core_clk(core_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .tx_disable_pin(pins[5]), .general_input_one(pins[4]), .rate_select_input(pins[3]),
        .fault_release(pins[2]), .loss_signal_release(pins[1]),
        .power_on_analog_trip(pins[0]), .conv_done(conv_done), .receive_power_coarse(coarse),
        .temp_result(m[0]), .temp_thr_hi(m[1]), .temp_thr_lo(m[2]), .vcc_result(m[3]),
        .vcc_thr_hi(m[4]), .vcc_thr_lo(m[5]), .mona_result(m[6]), .mona_thr_hi(m[7]),
        .mona_thr_lo(m[8]), .monb_result(m[9]), .monb_thr_hi(m[10]), .monb_thr_lo(m[11]),
        .tx_disabled(tx_disabled), .rate_select_output(rate_out),
        .measurement_alarm_flags_a(alarms));
    // compare one byte and count it
    task cmp(input [7:0] got, input [7:0] exp);
        begin
            checks = checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("ERROR t=%0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    // one-cycle strobe tasks; the strobe drops a cycle later, so re-entry is safe
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge core_clk);
            {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
            @(negedge core_clk);
            reg_wr = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        begin
            @(negedge core_clk);
            {reg_rd, reg_addr} = {1'b1, a};
            @(negedge core_clk);
            reg_rd = 1'b0;
            cmp(reg_rdata, exp);
        end
    endtask
    task pulse(input [5:0] d);
        begin
            @(negedge core_clk);
            conv_done = d;
            @(negedge core_clk);
            conv_done = 6'h00;
        end
    endtask
    // verdict, reached from the main sequence or the watchdog
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", checks, n_errors);
            if (n_errors == 0 && checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // watchdog at 5000 cycles, far beyond the some 53 cycles the tests need
    initial begin
        #200000;
        n_errors = n_errors + 1;
        tally_and_finish;
    end
    // test sequence
    initial begin
        for (i = 0; i < 12; i = i + 1)
            m[i] = TV[191-16*i -: 16];
        repeat (4) @(negedge core_clk);
        resetn = 1'b1;
        rd(8'h6E, 8'h01);
        rd(8'h6F, 8'h00);
        rd(8'h70, 8'h10);
        $display("test reset values done");
        pins = 6'h3E;
        rd(8'h6E, 8'hB6);
        wr(8'h6E, 8'hFF);
        pins = 6'h00;
        rd(8'h6E, 8'h48);
        cmp({6'h00, tx_disabled, rate_out}, 8'h03);
        wr(8'h6E, 8'h00);
        rd(8'h6E, 8'h00);
        cmp({6'h00, tx_disabled, rate_out}, 8'h00);
        $display("test pins and overrides done");
        coarse = 1'b1;
        pulse(6'h3F);
        rd(8'h70, 8'h66);
        rd(8'h6F, 8'hFD);
        wr(8'h6F, 8'h00);
        rd(8'h6F, 8'h01);
        pulse(6'h08);
        rd(8'h6F, 8'h21);
        $display("test conversions done");
        pins = 6'h01;
        rd(8'h70, 8'h76);
        pins = 6'h00;
        m[5] = 16'h8000;
        pulse(6'h10);
        rd(8'h70, 8'h66);
        m[3] = 16'h7FFF;
        pulse(6'h10);
        rd(8'h70, 8'h56);
        wr(8'h70, 8'h00);
        rd(8'h70, 8'h56);
        cmp(alarms, 8'h56);
        rd(8'h71, 8'h00);
        $display("test supply low and refusals done");
        resetn = 1'b0;
        @(negedge core_clk);
        resetn = 1'b1;
        rd(8'h6F, 8'h00);
        cmp(alarms, 8'h10);
        $display("test second reset done");
        tally_and_finish;
    end
endmodule // tb_top

//--- rtl/msab_bank.v
/*
 * status, conversion-ready and alarm register bank of a module controller.
 * holds three byte registers on the management bus:
 *   - pin status and override: pin reflections, two host overrides, not-ready;
 *   - conversion ready flags: per-channel done flags and the range flag;
 *   - alarm flags: high and low alarms of temperature, supply, monitors a and b.
 * every bit is volatile and rebuilt from reset and from the inputs.
 * assumes a management bus front end that issues one-cycle read/write
 * strobes with an 8-bit address, and a measurement engine that pulses a
 * per-channel done strobe with the result and thresholds held steady.
 * assumes the pins arrive already synchronous to core_clk; no synchroniser
 * is placed here, so an asynchronous pin must be staged before this block.
 * assumes the open-drain fault and loss-of-signal drivers live outside and
 * report their target states on fault_release and loss_signal_release.
 * the threshold registers and the shutdown logic that reads the alarms
 * are outside this block as well.
 */
`timescale 1ns/1ps
`include "msab_regs.vh"

module msab_bank #(
    parameter MEAS_W = 16
) (
    // clock and reset
    input  wire              core_clk,
    input  wire              resetn,
    // register access
    input  wire              reg_wr,
    input  wire              reg_rd,
    input  wire [7:0]        reg_addr,
    input  wire [7:0]        reg_wdata,
    output reg  [7:0]        reg_rdata,
    // pins and internal signals
    input  wire              tx_disable_pin,
    input  wire              general_input_one,
    input  wire              rate_select_input,
    input  wire              fault_release,
    input  wire              loss_signal_release,
    input  wire              power_on_analog_trip,
    // conversions: done strobes temp,vcc,mon a..d (bit 5..0)
    input  wire [5:0]        conv_done,
    input  wire              receive_power_coarse,
    input  wire [MEAS_W-1:0] temp_result,
    input  wire [MEAS_W-1:0] temp_thr_hi,
    input  wire [MEAS_W-1:0] temp_thr_lo,
    input  wire [MEAS_W-1:0] vcc_result,
    input  wire [MEAS_W-1:0] vcc_thr_hi,
    input  wire [MEAS_W-1:0] vcc_thr_lo,
    input  wire [MEAS_W-1:0] mona_result,
    input  wire [MEAS_W-1:0] mona_thr_hi,
    input  wire [MEAS_W-1:0] mona_thr_lo,
    input  wire [MEAS_W-1:0] monb_result,
    input  wire [MEAS_W-1:0] monb_thr_hi,
    input  wire [MEAS_W-1:0] monb_thr_lo,
    // controls to the rest of the device
    output reg               tx_disabled,
    output reg               rate_select_output,
    output reg  [7:0]        measurement_alarm_flags_a
);

    reg        tx_disable_sw_override;
    reg        rate_select_sw_override;
    reg [5:0]  conv_ready;
    reg        receive_power_range_flag;
    reg        tx_disable_pin_level;
    reg        general_input_one_level;
    reg        rate_select_pin_level;
    reg        fault_output_state;
    reg        loss_signal_output_state;
    reg        not_ready_flag;
    wire [7:0] pin_status_and_override;
    wire [7:0] conversion_ready_flags;
    reg  [7:0] next_rdata;
    wire       wr_pin;
    wire       wr_conv;

    // done strobe positions on conv_done, temperature first
    localparam N_CONV  = 6;
    localparam CH_TEMP = 5;
    localparam CH_VCC  = 4;
    localparam CH_MONA = 3;
    localparam CH_MONB = 2;
    localparam CH_MONC = 1;
    localparam [7:0] AL_RESET = `MSAB_AL_RESET;

    assign wr_pin  = reg_wr && (reg_addr == `MSAB_OFS_PIN_STATUS);
    assign wr_conv = reg_wr && (reg_addr == `MSAB_OFS_CONV_READY);

    // pin reflections, registered once so reads see a stable copy
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_disable_pin_level    <= 1'b0;
            general_input_one_level <= 1'b0;
            rate_select_pin_level   <= 1'b0;
        end else begin
            tx_disable_pin_level    <= tx_disable_pin;
            general_input_one_level <= general_input_one;
            rate_select_pin_level   <= rate_select_input;
        end
    end

    // output and supply states; not-ready starts set so a read in the
    // first cycle after reset never claims a good supply
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            fault_output_state       <= 1'b0;
            loss_signal_output_state <= 1'b0;
            not_ready_flag           <= 1'b1;
        end else begin
            fault_output_state       <= fault_release;
            loss_signal_output_state <= loss_signal_release;
            not_ready_flag           <= power_on_analog_trip;
        end
    end

    // host-writable overrides; only bits 6 and 3 take the write
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_disable_sw_override  <= 1'b0;
            rate_select_sw_override <= 1'b0;
        end else if (wr_pin) begin
            tx_disable_sw_override  <= reg_wdata[`MSAB_PS_TXD_OVR];
            rate_select_sw_override <= reg_wdata[`MSAB_PS_RATE_SELECT_INPUT_OVR];
        end
    end

    // transmit disable; the override can only force, never release, the pin
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            tx_disabled <= 1'b0;
        end else begin
            tx_disabled <= tx_disable_pin | tx_disable_sw_override;
        end
    end

    // rate select output, built the same way from its own pin and override
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rate_select_output <= 1'b0;
        end else begin
            rate_select_output <= rate_select_input | rate_select_sw_override;
        end
    end

    // ready flags: a done strobe in the clearing cycle wins over the clear,
    // so a conversion that lands as the host clears is never lost; the host
    // writes 0 to drop a flag and 1 to leave it alone
    genvar gi;
    generate
        for (gi = 0; gi < N_CONV; gi = gi + 1) begin : g_ready
            always @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    conv_ready[gi] <= 1'b0;
                end else if (conv_done[gi]) begin
                    conv_ready[gi] <= 1'b1;
                end else if (wr_conv && !reg_wdata[gi + `MSAB_CR_LOW_CH]) begin
                    conv_ready[gi] <= 1'b0;
                end
            end
        end
    endgenerate

    // range flag follows each monitor-three conversion (done bit 1);
    // the host cannot write it, it only changes with a new result
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            receive_power_range_flag <= 1'b0;
        end else if (conv_done[CH_MONC]) begin
            receive_power_range_flag <= receive_power_coarse;
        end
    end

    // threshold compares run every cycle; a flag only takes one on its done
    // strobe, so a threshold rewritten between conversions waits for a result
    wire next_temperature_high_alarm;
    wire next_temperature_low_alarm;
    wire next_supply_high_alarm;
    wire next_supply_low_alarm;
    wire next_mona_hi;
    wire next_mona_lo;
    wire next_monb_hi;
    wire next_monb_lo;

    // temperature is two's complement; the rest are unsigned codes
    assign next_temperature_high_alarm = $signed(temp_result) > $signed(temp_thr_hi);
    assign next_temperature_low_alarm = $signed(temp_result) < $signed(temp_thr_lo);
    assign next_supply_high_alarm  = vcc_result > vcc_thr_hi;
    assign next_supply_low_alarm  = vcc_result < vcc_thr_lo;
    assign next_mona_hi = mona_result > mona_thr_hi;
    assign next_mona_lo = mona_result < mona_thr_lo;
    assign next_monb_hi = monb_result > monb_thr_hi;
    assign next_monb_lo = monb_result < monb_thr_lo;

    // temperature alarms; equal to a threshold counts as inside the window
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            measurement_alarm_flags_a[`MSAB_AL_TEMPERATURE_HIGH_ALARM] <= AL_RESET[`MSAB_AL_TEMPERATURE_HIGH_ALARM];
            measurement_alarm_flags_a[`MSAB_AL_TEMPERATURE_LOW_ALARM] <= AL_RESET[`MSAB_AL_TEMPERATURE_LOW_ALARM];
        end else if (conv_done[CH_TEMP]) begin
            measurement_alarm_flags_a[`MSAB_AL_TEMPERATURE_HIGH_ALARM] <= next_temperature_high_alarm;
            measurement_alarm_flags_a[`MSAB_AL_TEMPERATURE_LOW_ALARM] <= next_temperature_low_alarm;
        end
    end

    // supply high alarm follows each supply result
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            measurement_alarm_flags_a[`MSAB_AL_SUPPLY_HIGH_ALARM] <= AL_RESET[`MSAB_AL_SUPPLY_HIGH_ALARM];
        end else if (conv_done[CH_VCC]) begin
            measurement_alarm_flags_a[`MSAB_AL_SUPPLY_HIGH_ALARM] <= next_supply_high_alarm;
        end
    end

    // supply below the trip forces the low alarm regardless of results;
    // only a result taken with supply back above the trip can clear it
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            measurement_alarm_flags_a[`MSAB_AL_SUPPLY_LOW_ALARM] <= AL_RESET[`MSAB_AL_SUPPLY_LOW_ALARM];
        end else if (power_on_analog_trip) begin
            measurement_alarm_flags_a[`MSAB_AL_SUPPLY_LOW_ALARM] <= 1'b1;
        end else if (conv_done[CH_VCC]) begin
            measurement_alarm_flags_a[`MSAB_AL_SUPPLY_LOW_ALARM] <= next_supply_low_alarm;
        end
    end

    // monitor a alarms
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            measurement_alarm_flags_a[`MSAB_AL_MONA_HI] <= AL_RESET[`MSAB_AL_MONA_HI];
            measurement_alarm_flags_a[`MSAB_AL_MONA_LO] <= AL_RESET[`MSAB_AL_MONA_LO];
        end else if (conv_done[CH_MONA]) begin
            measurement_alarm_flags_a[`MSAB_AL_MONA_HI] <= next_mona_hi;
            measurement_alarm_flags_a[`MSAB_AL_MONA_LO] <= next_mona_lo;
        end
    end

    // monitor b alarms
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            measurement_alarm_flags_a[`MSAB_AL_MONB_HI] <= AL_RESET[`MSAB_AL_MONB_HI];
            measurement_alarm_flags_a[`MSAB_AL_MONB_LO] <= AL_RESET[`MSAB_AL_MONB_LO];
        end else if (conv_done[CH_MONB]) begin
            measurement_alarm_flags_a[`MSAB_AL_MONB_HI] <= next_monb_hi;
            measurement_alarm_flags_a[`MSAB_AL_MONB_LO] <= next_monb_lo;
        end
    end

    // register images; field positions come from the shared map
    assign pin_status_and_override[`MSAB_PS_TXD_LEVEL]   = tx_disable_pin_level;
    assign pin_status_and_override[`MSAB_PS_TXD_OVR]     = tx_disable_sw_override;
    assign pin_status_and_override[`MSAB_PS_IN1_LEVEL]   = general_input_one_level;
    assign pin_status_and_override[`MSAB_PS_RATE_SELECT_INPUT_LEVEL]  = rate_select_pin_level;
    assign pin_status_and_override[`MSAB_PS_RATE_SELECT_INPUT_OVR]    = rate_select_sw_override;
    assign pin_status_and_override[`MSAB_PS_FAULT_STATE] = fault_output_state;
    assign pin_status_and_override[`MSAB_PS_LOS_STATE]   = loss_signal_output_state;
    assign pin_status_and_override[`MSAB_PS_NOT_READY]   = not_ready_flag;
    // bit 1 of the ready register is reserved and reads zero
    assign conversion_ready_flags[7:`MSAB_CR_LOW_CH] = conv_ready;
    assign conversion_ready_flags[1]                 = 1'b0;
    assign conversion_ready_flags[`MSAB_CR_RANGE]    = receive_power_range_flag;

    // read decode; unmapped addresses read zero so a host scan sees no ghosts
    always @* begin
        next_rdata = 8'h00;
        if (reg_addr == `MSAB_OFS_PIN_STATUS) begin
            next_rdata = pin_status_and_override;
        end else if (reg_addr == `MSAB_OFS_CONV_READY) begin
            next_rdata = conversion_ready_flags;
        end else if (reg_addr == `MSAB_OFS_ALARM_A) begin
            next_rdata = measurement_alarm_flags_a;
        end
    end

    // read data held until the next read strobe
    always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // msab_bank

//--- rtl/msab_regs.vh
/*
 * offsets, field positions and reset values of the status and alarm bank.
 * assumes inclusion by the bank module and its monitor; definitions only.
 */
`ifndef MSAB_REGS_VH
`define MSAB_REGS_VH

// register offsets on the management bus
`define MSAB_OFS_PIN_STATUS   8'h6E
`define MSAB_OFS_CONV_READY   8'h6F
`define MSAB_OFS_ALARM_A      8'h70

// pin_status_and_override fields
`define MSAB_PS_TXD_LEVEL     7
`define MSAB_PS_TXD_OVR       6
`define MSAB_PS_IN1_LEVEL     5
`define MSAB_PS_RATE_SELECT_INPUT_LEVEL    4
`define MSAB_PS_RATE_SELECT_INPUT_OVR      3
`define MSAB_PS_FAULT_STATE   2
`define MSAB_PS_LOS_STATE     1
`define MSAB_PS_NOT_READY     0

// conversion_ready_flags fields
`define MSAB_CR_TEMP          7
`define MSAB_CR_LOW_CH        2
`define MSAB_CR_RANGE         0
`define MSAB_CR_RESET         8'h00

// measurement_alarm_flags_a fields
`define MSAB_AL_TEMPERATURE_HIGH_ALARM       7
`define MSAB_AL_TEMPERATURE_LOW_ALARM       6
`define MSAB_AL_SUPPLY_HIGH_ALARM        5
`define MSAB_AL_SUPPLY_LOW_ALARM        4
`define MSAB_AL_MONA_HI       3
`define MSAB_AL_MONA_LO       2
`define MSAB_AL_MONB_HI       1
`define MSAB_AL_MONB_LO       0
`define MSAB_AL_RESET         8'h10

`endif
